// ===== logic/hub_strap_pkg.sv
package hub_strap_pkg;

    // configuration method chosen by {sel_hi, sel_mid, sel_lo}
    typedef enum logic [2:0] {
        CFG_DEFAULT = 3'h0,
        CFG_SMBUS = 3'h1,
        CFG_DEFAULT_BUSPWR = 3'h2,
        CFG_EEPROM = 3'h3,
        CFG_DPS = 3'h4,
        CFG_DPS_LED = 3'h5,
        CFG_DEFAULT_B = 3'h6,
        CFG_GANGED = 3'h7
    } cfg_method_t;

    localparam logic [6:0] SMBUS_SLAVE_ADDR = 7'h2C;
    localparam logic [6:0] SMBUS_ADDR_RST = 7'h00;
    localparam logic [1:0] FIXED_STRAP_RST = 2'h0;
    localparam logic [2:0] FIXED_PORTS_RST = 3'h0;
    localparam cfg_method_t CFG_METHOD_RST = CFG_DEFAULT;

    // bit positions of the pin vector inside the synchroniser
    localparam int PIN_RST_N = 0;
    localparam int PIN_POR = 1;
    localparam int PIN_SEL_HI = 2;
    localparam int PIN_SEL_MID = 3;
    localparam int PIN_SEL_LO = 4;
    localparam int PIN_STRAP_B0 = 5;
    localparam int PIN_STRAP_B1 = 6;
    localparam int PIN_COUNT = 7;

    // strap value to fixed-port mask, bit 0 is port 1
    function automatic logic [2:0] fixed_decode(input logic [1:0] strap);
        logic [2:0] mask;
        case (strap)
            2'h0: mask = 3'h0;
            2'h1: mask = 3'h1;
            2'h2: mask = 3'h3;
            default: mask = 3'h7;
        endcase
        return mask;
    endfunction

    function automatic logic strap_enabled(input cfg_method_t method);
        return (method == CFG_DEFAULT) || (method == CFG_DEFAULT_BUSPWR);
    endfunction

endpackage

// ===== logic/strap_sync_if.sv
`timescale 1ns/1ps
`default_nettype none

interface strap_sync_if;
    logic sel_hi;
    logic sel_mid;
    logic sel_lo;
    logic strap_b0;
    logic strap_b1;
    logic in_reset;
    logic release_pulse;

    modport src (
        output sel_hi,
        output sel_mid,
        output sel_lo,
        output strap_b0,
        output strap_b1,
        output in_reset,
        output release_pulse
    );

    modport dst (
        input sel_hi,
        input sel_mid,
        input sel_lo,
        input strap_b0,
        input strap_b1,
        input in_reset,
        input release_pulse
    );
endinterface

`default_nettype wire

// ===== logic/pin_sync_reset.sv
`timescale 1ns/1ps
`default_nettype none

module pin_sync_reset (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic reset_pin_n,
    input wire logic por_supplies_stable,
    input wire logic cfg_method_sel_hi,
    input wire logic cfg_method_sel_mid,
    input wire logic cfg_method_sel_lo,
    input wire logic fixed_port_strap_b0,
    input wire logic fixed_port_strap_b1,
    strap_sync_if.src link
);
    localparam int N = hub_strap_pkg::PIN_COUNT;

    typedef struct packed {
        logic [N-1:0] stage1;
        logic [N-1:0] stage2;
        logic in_reset;
        logic release_pulse;
    } sync_state_t;

    localparam sync_state_t SYNC_RST = '{
        stage1: '0,
        stage2: '0,
        in_reset: 1'b1,
        release_pulse: 1'b0
    };

    sync_state_t state;
    sync_state_t next_state;
    logic out_of_reset;

    // internal reset holds while the pin is low or supplies are not yet stable
    assign out_of_reset = state.stage2[hub_strap_pkg::PIN_RST_N]
        && state.stage2[hub_strap_pkg::PIN_POR];

    always_comb begin
        next_state = state;
        next_state.stage1 = {fixed_port_strap_b1, fixed_port_strap_b0, cfg_method_sel_lo,
            cfg_method_sel_mid, cfg_method_sel_hi, por_supplies_stable, reset_pin_n};
        next_state.stage2 = state.stage1;
        next_state.in_reset = !out_of_reset;
        next_state.release_pulse = state.in_reset && out_of_reset;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= SYNC_RST;
        end else begin
            state <= next_state;
        end
    end

    assign link.sel_hi = state.stage2[hub_strap_pkg::PIN_SEL_HI];
    assign link.sel_mid = state.stage2[hub_strap_pkg::PIN_SEL_MID];
    assign link.sel_lo = state.stage2[hub_strap_pkg::PIN_SEL_LO];
    assign link.strap_b0 = state.stage2[hub_strap_pkg::PIN_STRAP_B0];
    assign link.strap_b1 = state.stage2[hub_strap_pkg::PIN_STRAP_B1];
    assign link.in_reset = state.in_reset;
    assign link.release_pulse = state.release_pulse;

endmodule

`default_nettype wire

// ===== logic/hub_strap_and_status_pins.sv
// Notes on behaviour
// - latch upper config-select pin at reset release; with others it picks config method.
// - when the upper select pin is not bonded out it reads as zero.
// - internal reset holds logic until supplies stable and reset pin released.
// - active LED asserted only while configured and not suspended.
// - low on power sense means bus powered, high means local power present, except select 010 is always bus powered.
// - with straps enabled, both fixed-port bits are sampled at reset release.
// - fixed strap 00 none, 01 port1, 10 ports 1-2, 11 ports 1-3.
// - active LED is active high for strap 00 and 10, low for 01 and 11.
// - speed LED active high when mid select was 0, low when it was 1.
// - select 001 means SMBus slave at 0101100, straps ignored, registers rule.
`timescale 1ns/1ps
`default_nettype none

module hub_strap_and_status_pins #(
    parameter bit SEL_HI_BONDED = 1'b1
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic reset_pin_n,
    input wire logic por_supplies_stable,
    input wire logic cfg_method_sel_hi,
    input wire logic cfg_method_sel_lo,
    input wire logic fixed_port_strap_b1,
    input wire logic cfg_method_sel_mid,
    output logic upstream_speed_led_out,
    output logic upstream_speed_led_oe,
    input wire logic fixed_port_strap_b0,
    output logic active_state_led_out,
    output logic active_state_led_oe,
    input wire logic hub_configured,
    input wire logic hub_suspended,
    input wire logic hub_high_speed,
    output logic internal_rst,
    output hub_strap_pkg::cfg_method_t cfg_method,
    output logic strap_options_en,
    output logic smbus_slave_mode,
    output logic [6:0] smbus_slave_addr,
    output logic regs_control,
    output logic [2:0] fixed_ports,
    output logic self_powered
);

    typedef struct packed {
        hub_strap_pkg::cfg_method_t cfg_method;
        logic [1:0] fixed_strap;
        logic [2:0] fixed_ports;
        logic strap_en;
        logic self_powered;
        logic smbus_mode;
        logic regs_ctrl;
        logic [6:0] smbus_addr;
        logic internal_rst;
        logic active_out;
        logic active_oe;
        logic speed_out;
        logic speed_oe;
    } pins_state_t;

    localparam pins_state_t PINS_RST = '{
        cfg_method: hub_strap_pkg::CFG_METHOD_RST,
        fixed_strap: hub_strap_pkg::FIXED_STRAP_RST,
        fixed_ports: hub_strap_pkg::FIXED_PORTS_RST,
        strap_en: 1'b0,
        self_powered: 1'b0,
        smbus_mode: 1'b0,
        regs_ctrl: 1'b0,
        smbus_addr: hub_strap_pkg::SMBUS_ADDR_RST,
        internal_rst: 1'b1,
        active_out: 1'b0,
        active_oe: 1'b0,
        speed_out: 1'b0,
        speed_oe: 1'b0
    };

    strap_sync_if link ();

    pin_sync_reset u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .reset_pin_n(reset_pin_n),
        .por_supplies_stable(por_supplies_stable),
        .cfg_method_sel_hi(cfg_method_sel_hi),
        .cfg_method_sel_mid(cfg_method_sel_mid),
        .cfg_method_sel_lo(cfg_method_sel_lo),
        .fixed_port_strap_b0(fixed_port_strap_b0),
        .fixed_port_strap_b1(fixed_port_strap_b1),
        .link(link)
    );

    pins_state_t state;
    pins_state_t next_state;
    hub_strap_pkg::cfg_method_t sampled_method;
    logic sampled_hi;
    logic hub_active;

    // an unbonded upper select pad is seen as zero
    assign sampled_hi = SEL_HI_BONDED ? link.sel_hi : 1'b0;
    assign sampled_method = hub_strap_pkg::cfg_method_t'({sampled_hi, link.sel_mid,
        link.sel_lo});
    assign hub_active = hub_configured && !hub_suspended;

    always_comb begin
        next_state = state;
        if (link.release_pulse) begin
            // capture happens only here, so values hold until the next release
            next_state.cfg_method = sampled_method;
            next_state.strap_en = hub_strap_pkg::strap_enabled(sampled_method);
            if (hub_strap_pkg::strap_enabled(sampled_method)) begin
                next_state.fixed_strap = {link.strap_b1, link.strap_b0};
            end else begin
                next_state.fixed_strap = hub_strap_pkg::FIXED_STRAP_RST;
            end
            next_state.fixed_ports = hub_strap_pkg::fixed_decode(next_state.fixed_strap);
            next_state.self_powered = link.strap_b0
                && (sampled_method != hub_strap_pkg::CFG_DEFAULT_BUSPWR);
            next_state.smbus_mode = (sampled_method == hub_strap_pkg::CFG_SMBUS);
            next_state.regs_ctrl = (sampled_method == hub_strap_pkg::CFG_SMBUS)
                || (sampled_method == hub_strap_pkg::CFG_EEPROM);
            if (sampled_method == hub_strap_pkg::CFG_SMBUS) begin
                next_state.smbus_addr = hub_strap_pkg::SMBUS_SLAVE_ADDR;
            end else begin
                next_state.smbus_addr = hub_strap_pkg::SMBUS_ADDR_RST;
            end
        end
        if (link.in_reset) begin
            // pads float during reset so the straps can be read
            next_state.internal_rst = 1'b1;
            next_state.active_oe = 1'b0;
            next_state.speed_oe = 1'b0;
            next_state.active_out = 1'b0;
            next_state.speed_out = 1'b0;
        end else begin
            next_state.internal_rst = 1'b0;
            next_state.active_oe = 1'b1;
            next_state.speed_oe = 1'b1;
            next_state.active_out = hub_active ^ next_state.fixed_strap[0];
            next_state.speed_out = hub_high_speed ^ next_state.cfg_method[1];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= PINS_RST;
        end else begin
            state <= next_state;
        end
    end

    assign upstream_speed_led_out = state.speed_out;
    assign upstream_speed_led_oe = state.speed_oe;
    assign active_state_led_out = state.active_out;
    assign active_state_led_oe = state.active_oe;
    assign internal_rst = state.internal_rst;
    assign cfg_method = state.cfg_method;
    assign strap_options_en = state.strap_en;
    assign smbus_slave_mode = state.smbus_mode;
    assign smbus_slave_addr = state.smbus_addr;
    assign regs_control = state.regs_ctrl;
    assign fixed_ports = state.fixed_ports;
    assign self_powered = state.self_powered;

    default clocking cb @(posedge clk);
    endclocking

    default disable iff (sys_rst);

    sequence s_capture;
        link.release_pulse;
    endsequence

    sequence s_active_steady;
        hub_active && !link.in_reset;
    endsequence

    sequence s_default_cfg;
        cfg_method == hub_strap_pkg::CFG_DEFAULT;
    endsequence

    a_sel_hi_capture:
    assert property (s_capture |=> cfg_method[2] == (SEL_HI_BONDED && $past(link.sel_hi)))
    else $error("upper select bit not captured at reset release");

    a_sel_hi_absent:
    assert property (SEL_HI_BONDED || !cfg_method[2])
    else $error("unbonded upper select bit reads as one");

    a_values_hold:
    assert property (!link.release_pulse |=> $stable(cfg_method) && $stable(fixed_ports)
        && $stable(self_powered) && $stable(smbus_slave_addr))
    else $error("captured strap values changed without a reset release");

    a_fixed_capture:
    assert property (s_capture ##1 s_default_cfg |-> fixed_ports
        == hub_strap_pkg::fixed_decode({$past(link.strap_b1), $past(link.strap_b0)}))
    else $error("fixed port mask does not match sampled strap");

    a_fixed_values:
    assert property (fixed_ports inside {3'h0, 3'h1, 3'h3, 3'h7})
    else $error("fixed port mask is not a valid decode");

    a_led_asserted:
    assert property (s_active_steady ##1 s_active_steady |-> active_state_led_oe
        && active_state_led_out == !state.fixed_strap[0])
    else $error("active LED not asserted while hub active");

    a_led_negated:
    assert property (!hub_active && !link.in_reset |=> active_state_led_out
        == state.fixed_strap[0])
    else $error("active LED not negated while hub idle");

    a_speed_led:
    assert property (!link.in_reset |=> upstream_speed_led_out
        == ($past(hub_high_speed) ^ cfg_method[1]))
    else $error("speed LED polarity wrong");

    a_smbus_mode:
    assert property (smbus_slave_mode |-> smbus_slave_addr == hub_strap_pkg::SMBUS_SLAVE_ADDR
        && fixed_ports == 3'h0 && !strap_options_en && regs_control)
    else $error("SMBus mode settings inconsistent");

    a_self_power:
    assert property (s_capture |=> self_powered == ($past(link.strap_b0)
        && cfg_method != hub_strap_pkg::CFG_DEFAULT_BUSPWR))
    else $error("self power sense captured wrongly");

    a_reset_hold:
    assert property (link.in_reset |=> internal_rst && !active_state_led_oe
        && !upstream_speed_led_oe)
    else $error("logic released or pads driven during reset");

endmodule

`default_nettype wire

// ===== verif/board_model.sv
`timescale 1ns/1ps
`default_nettype none

// strap resistors on every select pad, LEDs sharing two of the pads
module board_model (
    input wire logic [4:0] strap,
    input wire logic speed_out,
    input wire logic speed_oe,
    input wire logic act_out,
    input wire logic act_oe,
    output logic sel_hi,
    output logic sel_mid,
    output logic sel_lo,
    output logic b1,
    output logic b0
);
    assign sel_hi = strap[4];
    assign sel_lo = strap[2];
    assign b1 = strap[1];
    // shared pads follow the driver while enabled, the resistor otherwise
    assign sel_mid = speed_oe ? speed_out : strap[3];
    assign b0 = act_oe ? act_out : strap[0];
endmodule

`default_nettype wire

// ===== verif/hub_strap_and_status_pins_test.sv
`timescale 1ns/1ps
`default_nettype none

module hub_strap_and_status_pins_test;
    logic clk, sys_rst, reset_pin_n, por_supplies_stable;
    logic hub_configured, hub_suspended, hub_high_speed;
    logic [4:0] strap;
    logic sel_hi, sel_mid, sel_lo, b1, b0;
    logic spd_out, spd_oe, act_out, act_oe, internal_rst;
    logic strap_options_en, smbus_slave_mode, regs_control, self_powered;
    logic [6:0] smbus_slave_addr;
    logic [2:0] fixed_ports;
    hub_strap_pkg::cfg_method_t cfg_method;
    int fails;
    int cmp_count;
    logic en;

    hub_strap_and_status_pins dut_u (.clk(clk), .sys_rst(sys_rst),
        .reset_pin_n(reset_pin_n), .por_supplies_stable(por_supplies_stable),
        .cfg_method_sel_hi(sel_hi), .cfg_method_sel_lo(sel_lo),
        .fixed_port_strap_b1(b1), .cfg_method_sel_mid(sel_mid),
        .upstream_speed_led_out(spd_out), .upstream_speed_led_oe(spd_oe),
        .fixed_port_strap_b0(b0), .active_state_led_out(act_out),
        .active_state_led_oe(act_oe), .hub_configured(hub_configured),
        .hub_suspended(hub_suspended), .hub_high_speed(hub_high_speed),
        .internal_rst(internal_rst), .cfg_method(cfg_method),
        .strap_options_en(strap_options_en), .smbus_slave_mode(smbus_slave_mode),
        .smbus_slave_addr(smbus_slave_addr), .regs_control(regs_control),
        .fixed_ports(fixed_ports), .self_powered(self_powered));

    board_model board_u (.strap(strap), .speed_out(spd_out), .speed_oe(spd_oe),
        .act_out(act_out), .act_oe(act_oe), .sel_hi(sel_hi), .sel_mid(sel_mid),
        .sel_lo(sel_lo), .b1(b1), .b0(b0));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    // hold reset long enough for the board, release, count edges to capture
    task automatic do_reset(input logic [4:0] s, input bit by_por);
        int n;
        hub_configured = 1'b0;
        hub_suspended = 1'b0;
        strap = s;
        if (by_por)
            por_supplies_stable = 1'b0;
        else
            reset_pin_n = 1'b0;
        step(41);
        chk("in reset", 8'h1, 8'(internal_rst));
        chk("oe in reset", 8'h0, 8'({spd_oe, act_oe}));
        reset_pin_n = 1'b1;
        por_supplies_stable = 1'b1;
        n = 0;
        while (internal_rst !== 1'b0 && n < 10) begin
            step(1);
            n++;
        end
        chk("release edges", 8'h4, 8'(n));
        chk("oe after", 8'h3, 8'({spd_oe, act_oe}));
    endtask

    task automatic led_check(input logic c, input logic sp, input logic exp);
        hub_configured = c;
        hub_suspended = sp;
        step(1);
        chk("active led", 8'(exp), 8'(act_out));
    endtask

    initial begin
        fails = 0;
        cmp_count = 0;
        sys_rst = 1'b1;
        reset_pin_n = 1'b1;
        por_supplies_stable = 1'b1;
        hub_configured = 1'b0;
        hub_suspended = 1'b0;
        hub_high_speed = 1'b1;
        strap = 5'h03;
        step(12);
        sys_rst = 1'b0;
        step(2);
        for (int m = 0; m < 8; m++) begin
            do_reset({m[2:0], 2'h3}, m[0]);
            en = (m == 0) || (m == 2);
            chk("method", 8'(m), 8'(cfg_method));
            chk("strap en", 8'(en), 8'(strap_options_en));
            chk("smbus", 8'(m == 1), 8'(smbus_slave_mode));
            chk("addr", (m == 1) ? 8'h2C : 8'h00, 8'(smbus_slave_addr));
            chk("regs", 8'(m == 1 || m == 3), 8'(regs_control));
            chk("fixed", en ? 8'h07 : 8'h00, 8'(fixed_ports));
            chk("self power", 8'(m != 2), 8'(self_powered));
            led_check(1'b1, 1'b0, ~en);
            chk("speed led", 8'(!m[1]), 8'(spd_out));
            hub_high_speed = 1'b0;
            step(1);
            chk("speed led fs", 8'(m[1]), 8'(spd_out));
            hub_high_speed = 1'b1;
        end
        for (int s = 0; s < 4; s++) begin
            do_reset({3'h0, s[1:0]}, 1'b0);
            chk("fixed", 8'({s == 3, s[1], s != 0}), 8'(fixed_ports));
            chk("self power", 8'(s[0]), 8'(self_powered));
            led_check(1'b1, 1'b0, ~s[0]);
            led_check(1'b1, 1'b1, s[0]);
            led_check(1'b0, 1'b0, s[0]);
            strap = {3'h7, ~s[1:0]};
            step(6);
            chk("held method", 8'h0, 8'(cfg_method));
            chk("held fixed", 8'({s == 3, s[1], s != 0}), 8'(fixed_ports));
        end
        close_out();
    end

    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        close_out();
    end
endmodule

`default_nettype wire
